// ==== hdl/cms_top.sv ====
// configuration sequencer: strap decode, load, initialise, user mode
//
// Contract
// R01: volatile configuration; a full load is needed after every power-up.
// R02: after loading, initialise registers and pins, then enter user mode.
// R03: done flag low at power-up and loading, high after; low on request.
// R04: user pins tri-stated during configuration, optional weak pull-ups.
// R05: init-done high while request low and first 40 config clocks.
// R06: the outside drives config clock to a level after configuration.
// R07: the outside drives the serial data bit to a definite level.
// R08: loading starts only when device and source both signal ready.
// R09: in passive modes a host controls loading and may reconfigure.
// R10: two straps: 00 serial or memory, 10 parallel sync, 11 async.
// R11: straps are sampled at each configuration start.
// R12: single strap: 0 serial or memory, 1 serial asynchronous.
// R13: two-strap pattern 01 is unsupported and does not load.
`timescale 1ns/1ps
module cms_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic config_request_n,
   input wire logic config_clock,
   input wire logic config_serial_bit,
   input wire logic mode_strap_hi,
   input wire logic mode_strap_lo,
   input wire logic mode_strap_single,
   input wire logic mem_ready,
   output logic config_complete_flag,
   output logic init_done_flag,
   output logic device_ready,
   output logic user_io_oe_n,
   output logic weak_pullup_en,
   output logic [2:0] load_mode
);

   localparam logic [15:0] INIT_LAST = 16'(cms_pkg::INIT_CYCLES - 1);
   localparam logic [15:0] EARLY_CLKS = 16'(cms_pkg::INIT_EARLY_CLOCKS);

   logic [cms_pkg::SYNC_W-1:0] pin_raw;
   logic [cms_pkg::SYNC_W-1:0] pin_s;
   logic [cms_pkg::SYNC_W-1:0] pin_rise;
   logic req_n_s;
   logic clk_rise;
   logic mem_rdy_s;

   cms_pkg::cms_state_t state_r;
   logic [2:0] mode_r;
   logic [15:0] bit_cnt_r;
   logic [15:0] init_cnt_r;
   logic [31:0] last_word_r;
   logic ctrl_single_r;
   logic ctrl_pullup_r;
   logic [15:0] load_len_r;
   logic [31:0] rdata_r;
   logic done_r;
   logic init_done_r;
   logic ready_r;
   logic oe_n_r;
   logic pullup_r;
   logic [2:0] decoded;
   logic [31:0] status_word;

   assign pin_raw = {mem_ready, mode_strap_single, mode_strap_lo,
                     mode_strap_hi, config_serial_bit, config_request_n,
                     config_clock};

   cms_sync #(
      .W(cms_pkg::SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(pin_raw),
      .q(pin_s),
      .rise(pin_rise)
   );

   assign req_n_s = pin_s[cms_pkg::LN_REQ_N];
   assign clk_rise = pin_rise[cms_pkg::LN_CLK];
   assign mem_rdy_s = pin_s[cms_pkg::LN_MEM_RDY];

   assign decoded = cms_pkg::cms_decode(ctrl_single_r,
                                        pin_s[cms_pkg::LN_SINGLE],
                                        pin_s[cms_pkg::LN_HI],
                                        pin_s[cms_pkg::LN_LO]);

   // sequencer; reset is power-up, so nothing runs before a load
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= cms_pkg::ST_POWERUP; // R01
         mode_r <= cms_pkg::MODE_SERIAL_OR_MEM;
      end
      else if (!req_n_s)
      begin
         state_r <= cms_pkg::ST_CLEAR; // R03
      end
      else
      begin
         case (state_r)
            cms_pkg::ST_POWERUP, cms_pkg::ST_CLEAR:
            begin
               mode_r <= decoded; // R11
               if (decoded == cms_pkg::MODE_BAD)
               begin
                  state_r <= cms_pkg::ST_BADMODE; // R13
               end
               else
               begin
                  state_r <= cms_pkg::ST_WAIT;
               end
            end
            cms_pkg::ST_WAIT:
            begin
               if (mem_rdy_s && ready_r)
               begin
                  state_r <= cms_pkg::ST_LOAD; // R08
               end
            end
            cms_pkg::ST_LOAD:
            begin
               if (clk_rise && (bit_cnt_r + 16'h0001 >= load_len_r))
               begin
                  state_r <= cms_pkg::ST_INIT; // R02
               end
            end
            cms_pkg::ST_INIT:
            begin
               if (init_cnt_r == INIT_LAST)
               begin
                  state_r <= cms_pkg::ST_USER; // R02
               end
            end
            cms_pkg::ST_USER, cms_pkg::ST_BADMODE:
            begin
               state_r <= state_r;
            end
            default:
            begin
               state_r <= cms_pkg::ST_POWERUP;
            end
         endcase
      end
   end

   // bit count and captured data, advanced on rising config clock edges
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_r <= 16'h0000;
         last_word_r <= 32'h0000_0000;
      end
      else if (state_r == cms_pkg::ST_LOAD)
      begin
         if (clk_rise)
         begin
            bit_cnt_r <= bit_cnt_r + 16'h0001;
            last_word_r <= {last_word_r[30:0],
                            pin_s[cms_pkg::LN_DATA]};
         end
      end
      else if (state_r == cms_pkg::ST_CLEAR ||
               state_r == cms_pkg::ST_WAIT)
      begin
         bit_cnt_r <= 16'h0000;
      end
   end

   // initialisation timer
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         init_cnt_r <= 16'h0000;
      end
      else if (state_r == cms_pkg::ST_INIT)
      begin
         init_cnt_r <= init_cnt_r + 16'h0001;
      end
      else
      begin
         init_cnt_r <= 16'h0000;
      end
   end

   // pin-facing status, one cycle behind the state
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         done_r <= 1'h0;
         init_done_r <= 1'h0;
         ready_r <= 1'h0;
         oe_n_r <= 1'h1;
         pullup_r <= 1'h0;
      end
      else
      begin
         done_r <= (state_r == cms_pkg::ST_INIT ||
                    state_r == cms_pkg::ST_USER) && req_n_s; // R03
         init_done_r <= state_r == cms_pkg::ST_CLEAR ||
                        state_r == cms_pkg::ST_WAIT ||
                        (state_r == cms_pkg::ST_LOAD &&
                         bit_cnt_r < EARLY_CLKS) ||
                        state_r == cms_pkg::ST_USER; // R05
         ready_r <= state_r == cms_pkg::ST_WAIT ||
                    state_r == cms_pkg::ST_LOAD; // R08
         oe_n_r <= state_r != cms_pkg::ST_USER; // R04
         pullup_r <= ctrl_pullup_r &&
                     state_r != cms_pkg::ST_USER; // R04
      end
   end

   // register writes
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ctrl_single_r <= cms_pkg::CTRL_SINGLE_RST;
         ctrl_pullup_r <= cms_pkg::CTRL_PULLUP_RST;
         load_len_r <= cms_pkg::LOAD_LEN_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == cms_pkg::ADDR_CTRL)
         begin
            ctrl_single_r <= reg_wdata[cms_pkg::CTRL_SINGLE_BIT];
            ctrl_pullup_r <= reg_wdata[cms_pkg::CTRL_PULLUP_BIT];
         end
         if (reg_addr == cms_pkg::ADDR_LOAD_LEN)
         begin
            load_len_r <= reg_wdata[15:0];
         end
      end
   end

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[cms_pkg::STATUS_STATE_LSB +: 3] = state_r;
      status_word[cms_pkg::STATUS_MODE_LSB +: 3] = mode_r;
      status_word[cms_pkg::STATUS_DONE_BIT] = done_r;
      status_word[cms_pkg::STATUS_INIT_BIT] = init_done_r;
      status_word[cms_pkg::STATUS_READY_BIT] = ready_r;
   end

   // register reads, data valid the cycle after the strobe only
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata_r <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            cms_pkg::ADDR_CTRL:
               rdata_r <= {30'h0, ctrl_pullup_r, ctrl_single_r};
            cms_pkg::ADDR_LOAD_LEN:
               rdata_r <= {16'h0000, load_len_r};
            cms_pkg::ADDR_STATUS:
               rdata_r <= status_word;
            cms_pkg::ADDR_BIT_CNT:
               rdata_r <= {16'h0000, bit_cnt_r};
            cms_pkg::ADDR_LAST_WORD:
               rdata_r <= last_word_r;
            default:
               rdata_r <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_r;
   assign config_complete_flag = done_r;
   assign init_done_flag = init_done_r;
   assign device_ready = ready_r;
   assign user_io_oe_n = oe_n_r;
   assign weak_pullup_en = pullup_r;
   assign load_mode = mode_r;

   AST_POWERUP_NO_DONE: assert property ( // R01
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_POWERUP |-> !config_complete_flag)
      else $error("done flag high before any load");

   AST_USER_AFTER_INIT: assert property ( // R02
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_USER) |->
         $past(state_r) == cms_pkg::ST_INIT &&
         $past(init_cnt_r) == INIT_LAST)
      else $error("user mode entered without full initialisation");

   AST_DONE_RISES: assert property ( // R03
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_LOAD ##1 state_r == cms_pkg::ST_INIT
         |=> config_complete_flag)
      else $error("done flag not raised after loading");

   AST_DONE_DROPS: assert property ( // R03
      @(posedge clk_sys) disable iff (rst)
      !req_n_s |-> ##2 !config_complete_flag)
      else $error("done flag not cleared by request");

   AST_IO_TRISTATE: assert property ( // R04
      @(posedge clk_sys) disable iff (rst)
      !user_io_oe_n |-> $past(state_r) == cms_pkg::ST_USER)
      else $error("user pins driven outside user mode");

   AST_INIT_EARLY_HIGH: assert property ( // R05
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_LOAD && bit_cnt_r < EARLY_CLKS
         |=> init_done_flag)
      else $error("init-done low in first config clocks");

   AST_HANDSHAKE: assert property ( // R08
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_LOAD) |->
         $past(mem_rdy_s) && device_ready)
      else $error("load began without both sides ready");

   AST_TWO_STRAP_DECODE: assert property ( // R10
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_WAIT) && !$past(ctrl_single_r) |->
         mode_r == cms_pkg::cms_decode(1'h0,
                                       1'h0,
                                       $past(pin_s[cms_pkg::LN_HI]),
                                       $past(pin_s[cms_pkg::LN_LO])))
      else $error("two-strap decode mismatch");

   AST_MODE_HELD: assert property ( // R11
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_LOAD && $past(state_r) == cms_pkg::ST_LOAD
         |-> $stable(mode_r))
      else $error("scheme changed during a load");

   AST_SINGLE_DECODE: assert property ( // R12
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_WAIT) && $past(ctrl_single_r) |->
         mode_r == ($past(pin_s[cms_pkg::LN_SINGLE]) ?
                    cms_pkg::MODE_SERIAL_ASYNC :
                    cms_pkg::MODE_SERIAL_OR_MEM))
      else $error("single-strap decode mismatch");

   AST_BAD_NO_LOAD: assert property ( // R13
      @(posedge clk_sys) disable iff (rst)
      mode_r == cms_pkg::MODE_BAD |-> state_r != cms_pkg::ST_LOAD &&
         state_r != cms_pkg::ST_WAIT)
      else $error("unsupported scheme began loading");

   COV_REACH_USER: cover property (
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_USER));

   COV_BAD_MODE: cover property (
      @(posedge clk_sys) disable iff (rst)
      $rose(state_r == cms_pkg::ST_BADMODE));

   COV_RECONFIG: cover property (
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_USER ##1 state_r == cms_pkg::ST_CLEAR);

   COV_SERIAL_ASYNC_LOAD: cover property (
      @(posedge clk_sys) disable iff (rst)
      state_r == cms_pkg::ST_LOAD &&
      mode_r == cms_pkg::MODE_SERIAL_ASYNC);

endmodule : cms_top

// ==== hdl/cms_pkg.sv ====
// constants, types and strap decode for the configuration sequencer
package cms_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES =
      (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_EARLY_CLOCKS = 40;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LOAD_LEN = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_BIT_CNT = 8'h0c;
   localparam logic [7:0] ADDR_LAST_WORD = 8'h10;

   // field positions
   localparam int CTRL_SINGLE_BIT = 0;
   localparam int CTRL_PULLUP_BIT = 1;
   localparam int STATUS_STATE_LSB = 0;
   localparam int STATUS_MODE_LSB = 4;
   localparam int STATUS_DONE_BIT = 8;
   localparam int STATUS_INIT_BIT = 9;
   localparam int STATUS_READY_BIT = 10;

   // reset values
   localparam logic CTRL_SINGLE_RST = 1'h0;
   localparam logic CTRL_PULLUP_RST = 1'h1;
   localparam logic [15:0] LOAD_LEN_RST = 16'h0100;

   // loading schemes
   localparam logic [2:0] MODE_SERIAL_OR_MEM = 3'h0;
   localparam logic [2:0] MODE_PAR_SYNC = 3'h1;
   localparam logic [2:0] MODE_PAR_ASYNC = 3'h2;
   localparam logic [2:0] MODE_SERIAL_ASYNC = 3'h3;
   localparam logic [2:0] MODE_BAD = 3'h7;

   // synchroniser lanes
   localparam int SYNC_W = 7;
   localparam int LN_CLK = 0;
   localparam int LN_REQ_N = 1;
   localparam int LN_DATA = 2;
   localparam int LN_HI = 3;
   localparam int LN_LO = 4;
   localparam int LN_SINGLE = 5;
   localparam int LN_MEM_RDY = 6;

   typedef enum logic [2:0]
   {
      ST_POWERUP,
      ST_CLEAR,
      ST_WAIT,
      ST_LOAD,
      ST_INIT,
      ST_USER,
      ST_BADMODE
   } cms_state_t;

   // strap pattern to loading scheme
   function automatic logic [2:0] cms_decode
   (
      input logic var_single,
      input logic single,
      input logic hi,
      input logic lo
   );
      logic [2:0] m;
      m = MODE_BAD;
      if (var_single)
      begin
         m = single ? MODE_SERIAL_ASYNC : MODE_SERIAL_OR_MEM;
      end
      else
      begin
         case ({hi, lo})
            2'h0: m = MODE_SERIAL_OR_MEM;
            2'h2: m = MODE_PAR_SYNC;
            2'h3: m = MODE_PAR_ASYNC;
            default: m = MODE_BAD;
         endcase
      end
      return m;
   endfunction : cms_decode

endpackage : cms_pkg

// ==== hdl/cms_sync.sv ====
// two-flop synchroniser bank with rising-edge detect
`timescale 1ns/1ps
module cms_sync #(
   parameter int W = 1
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] dly_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= '0;
         sync_r <= '0;
         dly_r <= '0;
      end
      else
      begin
         meta_r <= d;
         sync_r <= meta_r;
         dly_r <= sync_r;
      end
   end

   assign q = sync_r;
   assign rise = sync_r & ~dly_r;

endmodule : cms_sync

// ==== tb/cms_source.sv ====
// behavioural configuration source: bit clock, serial data, ready
`timescale 1ns/1ps
module cms_source (
   output logic config_clock,
   output logic config_serial_bit,
   output logic mem_ready
);
   initial
   begin
      config_clock = 1'b0;
      config_serial_bit = 1'b0;
      mem_ready = 1'b0;
   end

   task automatic set_ready(input logic v);
      mem_ready = v;
   endtask : set_ready

   // msb first, 80 ns per bit; clock rests low between frames
   task automatic send(input logic [31:0] w, input int n);
      int i;
      for (i = n - 1; i >= 0; i--)
      begin
         config_serial_bit = w[i];
         #40;
         config_clock = 1'b1;
         #40;
         config_clock = 1'b0;
      end
   endtask : send
endmodule : cms_source

// ==== tb/cms_top_bench.sv ====
// self-checking bench for the configuration sequencer
`timescale 1ns/1ps
`define CHK(got, exp) check(32'(got), 32'(exp));
`define WAIT_FOR(cond, n) \
   for (k = 0; k < (n) && (cond) !== 1'b1; k++) @(posedge clk_sys) #1; \
   if ((cond) !== 1'b1) timeout();
module cms_top_bench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic config_request_n = 1'b1;
   logic config_clock, config_serial_bit, mem_ready;
   logic mode_strap_hi = 1'b0;
   logic mode_strap_lo = 1'b0;
   logic mode_strap_single = 1'b0;
   logic config_complete_flag, init_done_flag, device_ready;
   logic user_io_oe_n, weak_pullup_en;
   logic [2:0] load_mode;
   logic [31:0] rv;
   int mismatches = 0;
   int n_compared = 0;
   int k;

   always #5 clk_sys = ~clk_sys;

   cms_top cms_top_inst (
      .clk_sys(clk_sys),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .config_request_n(config_request_n),
      .config_clock(config_clock),
      .config_serial_bit(config_serial_bit),
      .mode_strap_hi(mode_strap_hi),
      .mode_strap_lo(mode_strap_lo),
      .mode_strap_single(mode_strap_single),
      .mem_ready(mem_ready),
      .config_complete_flag(config_complete_flag),
      .init_done_flag(init_done_flag),
      .device_ready(device_ready),
      .user_io_oe_n(user_io_oe_n),
      .weak_pullup_en(weak_pullup_en),
      .load_mode(load_mode)
   );

   cms_source cms_source_inst (
      .config_clock(config_clock),
      .config_serial_bit(config_serial_bit),
      .mem_ready(mem_ready)
   );

   task automatic wrap_up;
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic timeout;
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
      wrap_up();
   endtask : timeout

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // hold the request low, judge the flags, then release
   task automatic request;
      @(posedge clk_sys);
      config_request_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK(config_complete_flag, 1'b0)
      `CHK(init_done_flag, 1'b1)
      `CHK(user_io_oe_n, 1'b1)
      @(posedge clk_sys);
      config_request_n <= 1'b1;
   endtask : request

   task automatic t_reset;
      `CHK(config_complete_flag, 1'b0)
      rd(cms_pkg::ADDR_CTRL, rv);
      `CHK(rv, 32'h2)
      rd(cms_pkg::ADDR_LOAD_LEN, rv);
      `CHK(rv, 32'h100)
      rd(8'h14, rv);
      `CHK(rv, 32'h0)
      repeat (50) @(posedge clk_sys);
      #1;
      `CHK(user_io_oe_n, 1'b1)
      `CHK(config_complete_flag, 1'b0)
   endtask : t_reset

   task automatic t_load;
      wr(cms_pkg::ADDR_LOAD_LEN, 32'd48);
      request();
      `WAIT_FOR(device_ready, 20)
      rd(cms_pkg::ADDR_STATUS, rv);
      `CHK(rv[2:0], 3'h2)
      `CHK(weak_pullup_en, 1'b1)
      cms_source_inst.set_ready(1'b1);
      cms_source_inst.send(32'h0000a5c3, 16);
      `CHK(init_done_flag, 1'b1)
      `CHK(user_io_oe_n, 1'b1)
      cms_source_inst.send(32'h3c5af00f, 32);
      `WAIT_FOR(config_complete_flag, 20)
      `CHK(init_done_flag, 1'b0)
      `CHK(user_io_oe_n, 1'b1)
      `WAIT_FOR(~user_io_oe_n, 120)
      `CHK(k >= 98, 1'b1)
      `CHK(config_complete_flag, 1'b1)
      `CHK(weak_pullup_en, 1'b0)
      `CHK(load_mode, 3'h0)
      rd(cms_pkg::ADDR_LAST_WORD, rv);
      `CHK(rv, 32'h3c5af00f)
      cms_source_inst.set_ready(1'b0);
   endtask : t_load

   // variant, single, hi, lo, expected scheme
   task automatic t_straps;
      logic [7:0] tbl [6] = '{8'h00, 8'h21, 8'h32, 8'h17, 8'h80, 8'hc3};
      int i;
      for (i = 0; i < 6; i++)
      begin
         wr(cms_pkg::ADDR_CTRL, {30'h0, 1'b1, tbl[i][7]});
         @(posedge clk_sys);
         mode_strap_single <= tbl[i][6];
         mode_strap_hi <= tbl[i][5];
         mode_strap_lo <= tbl[i][4];
         request();
         // let the release pass the synchroniser so load_mode is fresh
         repeat (5) @(posedge clk_sys);
         `WAIT_FOR(device_ready | (load_mode == 3'h7), 20)
         `CHK(load_mode, tbl[i][2:0])
         `CHK(device_ready, tbl[i][2:0] != 3'h7)
         if (tbl[i][2:0] == 3'h7)
         begin
            cms_source_inst.set_ready(1'b1);
            cms_source_inst.send(32'hff, 8);
            rd(cms_pkg::ADDR_STATUS, rv);
            `CHK(rv[2:0], 3'h6)
            `CHK(config_complete_flag, 1'b0)
            cms_source_inst.set_ready(1'b0);
         end
      end
   endtask : t_straps

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_straps();
      wrap_up();
   end

   initial
   begin
      #200000;
      timeout();
   end
endmodule : cms_top_bench
